// ==== include/bmlr_map.vh ====
// Register map constants for the buck mode and limit register bank
// Notes on behaviour
// - Discharge enable bit4 of 0x12, resets 1
// - Selector low uses low_sel_forced_mode, bit7 0x14
// - Selector high uses high_sel_forced_mode, bit6 0x14
// - Mode bit 0 allows automatic mode switching
// - Mode bit 1 forces continuous pulse-width only
// - Peak limit code bits7:6 of 0x16, reset 11
`ifndef BMLR_MAP_VH
`define BMLR_MAP_VH
`define BMLR_ADDR_DISCH       8'h12
`define BMLR_ADDR_MODE        8'h14
`define BMLR_ADDR_LIMIT       8'h16
`define BMLR_DISCH_BIT        4
`define BMLR_LOW_MODE_BIT     7
`define BMLR_HIGH_MODE_BIT    6
`define BMLR_LIMIT_HI         7
`define BMLR_LIMIT_LO         6
`define BMLR_DISCH_RST        1'b1
`define BMLR_LOW_MODE_RST     1'b0
`define BMLR_HIGH_MODE_RST    1'b0
`define BMLR_LIMIT_RST        2'h3
`define BMLR_LIMIT_4P7        2'h0
`define BMLR_LIMIT_5P2        2'h1
`define BMLR_LIMIT_5P7        2'h2
`define BMLR_LIMIT_6P2        2'h3
`define BMLR_FPWM_RST         1'b0
`define BMLR_AUTO_RST         1'b1
`define BMLR_ONEHOT_RST       4'h8
`define BMLR_ONEHOT_4P7       4'h1
`define BMLR_ONEHOT_5P2       4'h2
`define BMLR_ONEHOT_5P7       4'h4
`define BMLR_ONEHOT_6P2       4'h8
`define BMLR_RDATA_RST        8'h00
`endif

// ==== hw/bmlr_sync.v ====
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module bmlr_sync (
   // Clock and reset
   input  wire clk,
   input  wire rstn,
   // Level
   input  wire d,
   output wire q
);
   reg meta_r;
   reg q_r;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= 1'b0;
         q_r    <= 1'b0;
      end else begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end
   assign q = q_r;
endmodule // bmlr_sync
`default_nettype wire

// ==== hw/bmlr_regs.v ====
// Discharge, switching mode and peak current limit register bank
`timescale 1ns/1ps
`default_nettype none
`include "bmlr_map.vh"
module bmlr_regs (
   // Clock and reset
   input  wire       clk,
   input  wire       rstn,
   // Register port from the serial decoder
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_rd,
   output wire [7:0] reg_rdata,
   // Pin
   input  wire       voltage_select_pin,
   // Power stage controls
   output wire       discharge_en,
   output wire       forced_pwm,
   output wire       auto_mode,
   output wire [1:0] peak_limit_code,
   output wire [3:0] peak_limit_onehot
);
   // Address decode and write strobes
   wire       hit_disch;
   wire       hit_mode;
   wire       hit_limit;
   wire       wr_disch;
   wire       wr_mode;
   wire       wr_limit;
   // Synchronised selector and the mode bit it picks
   wire       voltage_select_pin_s;
   reg        sel_mode;
   // Stored fields
   reg        disch_r;
   reg        disch_nxt;
   reg        low_mode_r;
   reg        low_mode_nxt;
   reg        high_mode_r;
   reg        high_mode_nxt;
   reg  [1:0] limit_r;
   reg  [1:0] limit_nxt;
   // Controls towards the power stage
   reg        fpwm_r;
   reg        fpwm_nxt;
   reg        auto_r;
   reg        auto_nxt;
   reg  [3:0] onehot_r;
   reg  [3:0] onehot_nxt;
   // Read path
   reg  [7:0] rdata_r;
   reg  [7:0] rdata_nxt;

   bmlr_sync u_voltage_select_pin_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (voltage_select_pin),
      .q    (voltage_select_pin_s)
   );

   // Address decode
   assign hit_disch = (reg_addr == `BMLR_ADDR_DISCH);
   assign hit_mode  = (reg_addr == `BMLR_ADDR_MODE);
   assign hit_limit = (reg_addr == `BMLR_ADDR_LIMIT);
   assign wr_disch  = reg_wr & hit_disch;
   assign wr_mode   = reg_wr & hit_mode;
   assign wr_limit  = reg_wr & hit_limit;

   // Only the documented bits store; reserved write data is dropped
   always @* begin
      disch_nxt = disch_r;
      if (wr_disch) begin
         disch_nxt = reg_wdata[`BMLR_DISCH_BIT];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         disch_r <= `BMLR_DISCH_RST;
      end else begin
         disch_r <= disch_nxt;
      end
   end

   always @* begin
      low_mode_nxt = low_mode_r;
      if (wr_mode) begin
         low_mode_nxt = reg_wdata[`BMLR_LOW_MODE_BIT];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_mode_r <= `BMLR_LOW_MODE_RST;
      end else begin
         low_mode_r <= low_mode_nxt;
      end
   end

   always @* begin
      high_mode_nxt = high_mode_r;
      if (wr_mode) begin
         high_mode_nxt = reg_wdata[`BMLR_HIGH_MODE_BIT];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         high_mode_r <= `BMLR_HIGH_MODE_RST;
      end else begin
         high_mode_r <= high_mode_nxt;
      end
   end

   always @* begin
      limit_nxt = limit_r;
      if (wr_limit) begin
         limit_nxt = reg_wdata[`BMLR_LIMIT_HI:`BMLR_LIMIT_LO];
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         limit_r <= `BMLR_LIMIT_RST;
      end else begin
         limit_r <= limit_nxt;
      end
   end

   // Selector level picks which stored bit steers the power stage
   always @* begin
      if (voltage_select_pin_s) begin
         sel_mode = high_mode_r;
      end else begin
         sel_mode = low_mode_r;
      end
   end

   // Forced PWM and automatic operation are exact complements
   always @* begin
      fpwm_nxt = sel_mode;
      auto_nxt = ~sel_mode;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fpwm_r <= `BMLR_FPWM_RST;
      end else begin
         fpwm_r <= fpwm_nxt;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         auto_r <= `BMLR_AUTO_RST;
      end else begin
         auto_r <= auto_nxt;
      end
   end

   // Limit decode runs one cycle behind the stored code
   always @* begin
      case (limit_r)
         `BMLR_LIMIT_4P7: begin
            onehot_nxt = `BMLR_ONEHOT_4P7;
         end
         `BMLR_LIMIT_5P2: begin
            onehot_nxt = `BMLR_ONEHOT_5P2;
         end
         `BMLR_LIMIT_5P7: begin
            onehot_nxt = `BMLR_ONEHOT_5P7;
         end
         default: begin
            onehot_nxt = `BMLR_ONEHOT_6P2;
         end
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         onehot_r <= `BMLR_ONEHOT_RST;
      end else begin
         onehot_r <= onehot_nxt;
      end
   end

   // Reserved and unmapped bits read as zero; a same-cycle write is not seen
   always @* begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         rdata_nxt = `BMLR_RDATA_RST;
         case (reg_addr)
            `BMLR_ADDR_DISCH: begin
               rdata_nxt[`BMLR_DISCH_BIT] = disch_r;
            end
            `BMLR_ADDR_MODE: begin
               rdata_nxt[`BMLR_LOW_MODE_BIT]  = low_mode_r;
               rdata_nxt[`BMLR_HIGH_MODE_BIT] = high_mode_r;
            end
            `BMLR_ADDR_LIMIT: begin
               rdata_nxt[`BMLR_LIMIT_HI:`BMLR_LIMIT_LO] = limit_r;
            end
            default: begin
               rdata_nxt = `BMLR_RDATA_RST;
            end
         endcase
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_r <= `BMLR_RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs
   assign reg_rdata         = rdata_r;
   assign discharge_en      = disch_r;
   assign forced_pwm        = fpwm_r;
   assign auto_mode         = auto_r;
   assign peak_limit_code   = limit_r;
   assign peak_limit_onehot = onehot_r;
endmodule // bmlr_regs
`default_nettype wire

// ==== dv/bmlr_monitor.sv ====
// Port checker of the bank
`timescale 1ns/1ps
`default_nettype none
module bmlr_monitor (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Pin
   input wire logic       voltage_select_pin,
   // Power stage controls
   input wire logic       discharge_en,
   input wire logic       forced_pwm,
   input wire logic       auto_mode,
   input wire logic [1:0] peak_limit_code,
   input wire logic [3:0] peak_limit_onehot
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_mw;
      reg_wr && reg_addr==8'h14 && reg_wdata[7]==reg_wdata[6];
   endsequence
   sequence s_mw_diff;
      reg_wr && reg_addr==8'h14 && reg_wdata[7]!=reg_wdata[6];
   endsequence
   // Pin reaches the mode output three edges late, through the synchroniser
   AST_SEL: assert property (s_mw_diff |-> ##2
      forced_pwm==($past(voltage_select_pin, 3) ?
      $past(reg_wdata[6], 2) : $past(reg_wdata[7], 2))) else $error("bad");
   AST_DIS: assert property (reg_wr && reg_addr==8'h12 |=>
      discharge_en==$past(reg_wdata[4])) else $error("bad");
   AST_LIM: assert property (reg_wr && reg_addr==8'h16 |=>
      peak_limit_code==$past(reg_wdata[7:6])) else $error("bad");
   AST_HOT: assert property (
      peak_limit_onehot==4'h1<<$past(peak_limit_code)) else $error("bad");
   AST_MODE: assert property (s_mw |-> ##2
      forced_pwm==$past(reg_wdata[7], 2)) else $error("bad");
   AST_AUTO: assert property (auto_mode!=forced_pwm) else $error("bad");
   AST_UNM: assert property (reg_rd && reg_addr[0] |=>
      reg_rdata==8'h00) else $error("bad");
endmodule // bmlr_monitor
bind bmlr_regs bmlr_monitor i_mon (
   .clk                (clk),
   .rstn               (rstn),
   .reg_addr           (reg_addr),
   .reg_wr             (reg_wr),
   .reg_wdata          (reg_wdata),
   .reg_rd             (reg_rd),
   .reg_rdata          (reg_rdata),
   .voltage_select_pin (voltage_select_pin),
   .discharge_en       (discharge_en),
   .forced_pwm         (forced_pwm),
   .auto_mode          (auto_mode),
   .peak_limit_code    (peak_limit_code),
   .peak_limit_onehot  (peak_limit_onehot)
);
`default_nettype wire

// ==== dv/bmlr_host.sv ====
// Host model issuing register strobes
`timescale 1ns/1ps
`default_nettype none
module bmlr_host (
   // Clock
   input  wire logic       clk,
   // Register port
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr  = 8'h00,
   output logic      [7:0] reg_wdata = 8'h00,
   output logic            reg_wr    = 1'b0,
   output logic            reg_rd    = 1'b0
);
   // One strobe cycle, then idle cycles showing inverted address and data
   task xf(input logic [7:0] a, d, input logic w, output logic [7:0] q);
      @(negedge clk) {reg_addr, reg_wdata, reg_wr, reg_rd}={a, d, w, !w};
      @(negedge clk) {reg_addr, reg_wdata, reg_wr, reg_rd, q}={~a, ~d, 2'b00, reg_rdata};
      repeat (2) @(negedge clk);
   endtask
   // Output rail held up by another source: turn the discharge path off
   task standby_held(output logic [7:0] q);
      xf(8'h12, 8'h00, 1'b1, q);
   endtask
endmodule // bmlr_host
`default_nettype wire

// ==== dv/testbench.sv ====
// Bank testbench
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk=1'b0, rstn=1'b0, voltage_select_pin=1'b0, d=1'b1, reg_wr, reg_rd;
   logic discharge_en, forced_pwm, auto_mode;
   logic [1:0] m=2'h0, l=2'h3, peak_limit_code;
   logic [3:0] peak_limit_onehot;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, x, v, q;
   logic [8:0] ctrl;
   int err_count=0, tests_run=0, seed=57;
   always #12.5 clk=~clk;
   assign ctrl = {discharge_en, forced_pwm, auto_mode, peak_limit_code, peak_limit_onehot};
   bmlr_host i_host (
      .clk       (clk),
      .reg_rdata (reg_rdata),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd)
   );
   bmlr_regs i_dut (
      .clk                (clk),
      .rstn               (rstn),
      .reg_addr           (reg_addr),
      .reg_wr             (reg_wr),
      .reg_wdata          (reg_wdata),
      .reg_rd             (reg_rd),
      .reg_rdata          (reg_rdata),
      .voltage_select_pin (voltage_select_pin),
      .discharge_en       (discharge_en),
      .forced_pwm         (forced_pwm),
      .auto_mode          (auto_mode),
      .peak_limit_code    (peak_limit_code),
      .peak_limit_onehot  (peak_limit_onehot)
   );
   // Read value due at address a from the shadow fields
   function automatic logic [7:0] exp_rdata(input logic [7:0] a);
      if (a == 8'h12) return {3'h0, d, 4'h0};
      else if (a == 8'h14) return {m, 6'h00};
      else if (a == 8'h16) return {l, 6'h00};
      else return 8'h00;
   endfunction
   // Control outputs due at selector level s
   function automatic logic [8:0] exp_ctrl(input logic s);
      logic sel;
      sel = s ? m[0] : m[1];
      return {d, sel, !sel, l, 4'h1 << l};
   endfunction
   task ck_rd(input logic [7:0] g, e);
      tests_run++;
      if (g!==e) begin
         err_count++;
         $display("wrong value %0t %h %h", $time, g, e);
      end
   endtask
   task ck_ctrl(input logic [8:0] g, e);
      tests_run++;
      if (g!==e) begin
         err_count++;
         $display("wrong value %0t %h %h", $time, g, e);
      end
   endtask
   task end_of_test;
      if (err_count==0 && tests_run>0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rstn=1'b1;
      for (int i=0; i<64; i++) begin
         @(negedge clk) voltage_select_pin=i<24 ? 1'(i/12) : 1'($random(seed));
         x=i<24 ? 8'(18+i%3*2) : {5'h02, 3'($random(seed))};
         v=i<24 ? {2'(i/3), 1'b1, i[1], 4'hF} : 8'($random(seed));
         i_host.xf(x, 8'h00, 1'b0, q);
         ck_rd(q, exp_rdata(x));
         ck_ctrl(ctrl, exp_ctrl(voltage_select_pin));
         i_host.xf(x, v, 1'b1, q);
         if (x==8'h12) d=v[4];
         if (x==8'h14) m=v[7:6];
         if (x==8'h16) l=v[7:6];
      end
      i_host.standby_held(q);
      d=1'b0;
      ck_ctrl(ctrl, exp_ctrl(voltage_select_pin));
      i_host.xf(8'h12, 8'h00, 1'b0, q);
      ck_rd(q, exp_rdata(8'h12));
      end_of_test;
   end
   initial begin
      #30us;
      err_count++;
      end_of_test;
   end
endmodule // testbench
`default_nettype wire
